// ### vdc_channel.v
/*
 * One voltage output channel: control register and held output code.
 * Assumes write strobes and a byte-lane mask from the bus slave above,
 * all on ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vdc_regs.vh"

module vdc_channel #(
	parameter HAS_LOAD_BITS = 0
) (
	input wire ref_clk,
	input wire rst,
	input wire ctrl_we,
	input wire data_we,
	input wire [31:0] wdata,
	input wire [31:0] wmask,
	output wire power_down,
	output wire enable,
	output wire [1:0] reference_select,
	output wire increased_drive,
	output wire high_cap_load,
	output wire [11:0] output_code,
	output wire [15:0] ctrl_read,
	output wire [31:0] data_read
);
	localparam [15:0] CTRL_MASK = HAS_LOAD_BITS ? `VDC_CTRL_MASK_LOAD : `VDC_CTRL_MASK_BASIC;

	reg [15:0] ctrl;
	reg [11:0] code;
	wire [15:0] ctrl_bits;
	wire [15:0] next_ctrl;
	wire [11:0] code_mask;
	wire [11:0] next_code;
	wire enable_after;

	assign ctrl_bits = wmask[15:0] & CTRL_MASK;
	assign next_ctrl = (ctrl & ~ctrl_bits) | (wdata[15:0] & ctrl_bits);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl <= `VDC_CTRL_RESET;
		end else if (ctrl_we) begin
			ctrl <= next_ctrl;
		end
	end

	// Enable as it stands after this edge, so a disabling write clears at once
	assign enable_after = ctrl_we ? next_ctrl[`VDC_EN_BIT] : ctrl[`VDC_EN_BIT];
	assign code_mask = wmask[`VDC_CODE_MSB:`VDC_CODE_LSB];
	assign next_code = (code & ~code_mask) | (wdata[`VDC_CODE_MSB:`VDC_CODE_LSB] & code_mask);

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			code <= `VDC_CODE_RESET;
		end else if (!enable_after) begin
			code <= `VDC_CODE_RESET;
		end else if (data_we) begin
			code <= next_code;
		end
	end

	assign power_down = ctrl[`VDC_PD_BIT];
	assign enable = ctrl[`VDC_EN_BIT];
	assign reference_select = ctrl[`VDC_REF_MSB:`VDC_REF_LSB];
	assign increased_drive = ctrl[`VDC_DRV_BIT] & (HAS_LOAD_BITS != 0);
	assign high_cap_load = ctrl[`VDC_LOAD_BIT] & (HAS_LOAD_BITS != 0);
	assign output_code = code;
	assign ctrl_read = ctrl & CTRL_MASK;
	assign data_read = {4'h0, code, 16'h0000};
endmodule // vdc_channel

`default_nettype wire

// ### vdc_regs.vh
/*
 * Register map, field positions and reset values of the voltage
 * output channel control block (channels 3 to 6).
 * Assumes inclusion by bare name from the design files.
 */
`ifndef VDC_REGS_VH
`define VDC_REGS_VH

`define VDC_CH3_CTRL_ADDR 32'h4008240c
`define VDC_CH4_CTRL_ADDR 32'h40082410
`define VDC_CH5_CTRL_ADDR 32'h40082414
`define VDC_CH6_CTRL_ADDR 32'h40082418

`define VDC_CH3_DATA_ADDR 32'h40086410
`define VDC_CH4_DATA_ADDR 32'h40086414
`define VDC_CH5_DATA_ADDR 32'h40086418
`define VDC_CH6_DATA_ADDR 32'h4008641c

`define VDC_REF_LSB 0
`define VDC_REF_MSB 1
`define VDC_EN_BIT 4
`define VDC_PD_BIT 8
`define VDC_LOAD_BIT 9
`define VDC_DRV_BIT 10
`define VDC_CODE_LSB 16
`define VDC_CODE_MSB 27
`define VDC_CODE_W 12

`define VDC_CTRL_RESET 16'h0100
`define VDC_CODE_RESET 12'h000
`define VDC_CTRL_MASK_BASIC 16'h01ff
`define VDC_CTRL_MASK_LOAD 16'h07ff

`define VDC_REF_INTERNAL 2'h0
`define VDC_REF_SUPPLY 2'h3

`define VDC_HTRANS_NONSEQ_BIT 1
`define VDC_HSIZE_BYTE 3'h0
`define VDC_HSIZE_HALF 3'h1

`endif

// ### vdc_top.v
/*
 * AHB-Lite register slave for four voltage output channels (3 to 6),
 * each with a control register and a data register.
 * Assumes a single slave on the bus, so hready equals hreadyout, and
 * that every bus signal is synchronous to ref_clk.
 */
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "vdc_regs.vh"

// Function
// - Control bit 8 is power-down, resets to one; zero powers channel up.
// - Control bit 4 enables the channel; zero clears held code immediately.
// - Bits 1:0 pick reference: 00 internal, 11 supply; 01, 10 reserved.
// - Reference select writes reach the channel at once, no deferral.
// - Channels 4 and 5 add drive bit 10 and load bit 9, reset zero.
// - Channels 3 and 6 reserve bits 15:9; channels 4, 5 reserve 15:11.
// - Each channel has a data word, code in bits 27:16, rest reserved.
module vdc_top (
	input wire ref_clk,
	input wire rst,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	output wire ch3_power_down,
	output wire ch3_enable,
	output wire [1:0] ch3_reference_select,
	output wire [11:0] ch3_output_code,
	output wire ch4_power_down,
	output wire ch4_enable,
	output wire [1:0] ch4_reference_select,
	output wire ch4_increased_drive,
	output wire ch4_high_cap_load,
	output wire [11:0] ch4_output_code,
	output wire ch5_power_down,
	output wire ch5_enable,
	output wire [1:0] ch5_reference_select,
	output wire ch5_increased_drive,
	output wire ch5_high_cap_load,
	output wire [11:0] ch5_output_code,
	output wire ch6_power_down,
	output wire ch6_enable,
	output wire [1:0] ch6_reference_select,
	output wire [11:0] ch6_output_code
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_WRITE = 2'h1;
	localparam [1:0] ST_READ_WAIT = 2'h2;
	localparam [1:0] ST_READ_DONE = 2'h3;

	reg [1:0] state;
	reg [1:0] next_state;
	reg [31:0] addr_q;
	reg [31:0] mask_q;
	reg [31:0] next_hrdata;
	wire accept;
	wire [15:0] ch3_ctrl_read;
	wire [15:0] ch4_ctrl_read;
	wire [15:0] ch5_ctrl_read;
	wire [15:0] ch6_ctrl_read;
	wire [31:0] ch3_data_read;
	wire [31:0] ch4_data_read;
	wire [31:0] ch5_data_read;
	wire [31:0] ch6_data_read;
	wire commit;
	wire [3:0] ctrl_hit;
	wire [3:0] data_hit;

	// Byte lanes touched by a transfer; sub-word writes leave other lanes alone
	function [31:0] lane_mask;
		input [2:0] size;
		input [1:0] low;
		begin
			case (size)
				`VDC_HSIZE_BYTE: begin
					lane_mask = 32'h000000ff << {low, 3'h0};
				end
				`VDC_HSIZE_HALF: begin
					lane_mask = low[1] ? 32'hffff0000 : 32'h0000ffff;
				end
				default: begin
					lane_mask = 32'hffffffff;
				end
			endcase
		end
	endfunction

	// Word-aligned match against one register address
	function hit;
		input [31:0] a;
		input [31:0] reg_addr;
		begin
			hit = (a[31:2] == reg_addr[31:2]);
		end
	endfunction

	assign accept = hsel & hready & htrans[`VDC_HTRANS_NONSEQ_BIT];

	// A read costs one wait state so a write just before it is always seen
	assign hreadyout = (state != ST_READ_WAIT);
	assign hresp = 1'b0;

	always @* begin
		next_state = ST_IDLE;
		case (state)
			ST_READ_WAIT: begin
				next_state = ST_READ_DONE;
			end
			ST_IDLE, ST_WRITE, ST_READ_DONE: begin
				if (accept) begin
					next_state = hwrite ? ST_WRITE : ST_READ_WAIT;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			addr_q <= 32'h00000000;
			mask_q <= 32'h00000000;
		end else begin
			state <= next_state;
			if (accept) begin
				addr_q <= haddr;
				mask_q <= lane_mask(hsize, haddr[1:0]);
			end
		end
	end

	assign commit = (state == ST_WRITE);

	assign ctrl_hit[0] = hit(addr_q, `VDC_CH3_CTRL_ADDR);
	assign ctrl_hit[1] = hit(addr_q, `VDC_CH4_CTRL_ADDR);
	assign ctrl_hit[2] = hit(addr_q, `VDC_CH5_CTRL_ADDR);
	assign ctrl_hit[3] = hit(addr_q, `VDC_CH6_CTRL_ADDR);
	assign data_hit[0] = hit(addr_q, `VDC_CH3_DATA_ADDR);
	assign data_hit[1] = hit(addr_q, `VDC_CH4_DATA_ADDR);
	assign data_hit[2] = hit(addr_q, `VDC_CH5_DATA_ADDR);
	assign data_hit[3] = hit(addr_q, `VDC_CH6_DATA_ADDR);

	// reserved reads zero
	// Unmapped addresses read zero and ignore writes
	always @* begin
		next_hrdata = 32'h00000000;
		case (1'b1)
			ctrl_hit[0]: begin
				next_hrdata = {16'h0000, ch3_ctrl_read};
			end
			ctrl_hit[1]: begin
				next_hrdata = {16'h0000, ch4_ctrl_read};
			end
			ctrl_hit[2]: begin
				next_hrdata = {16'h0000, ch5_ctrl_read};
			end
			ctrl_hit[3]: begin
				next_hrdata = {16'h0000, ch6_ctrl_read};
			end
			data_hit[0]: begin
				next_hrdata = ch3_data_read;
			end
			data_hit[1]: begin
				next_hrdata = ch4_data_read;
			end
			data_hit[2]: begin
				next_hrdata = ch5_data_read;
			end
			data_hit[3]: begin
				next_hrdata = ch6_data_read;
			end
			default: begin
				next_hrdata = 32'h00000000;
			end
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (state == ST_READ_WAIT) begin
			hrdata <= next_hrdata;
		end
	end

	vdc_channel #(
		.HAS_LOAD_BITS(0)
	) u_ch3 (
		.ref_clk(ref_clk),
		.rst(rst),
		.ctrl_we(commit & ctrl_hit[0]),
		.data_we(commit & data_hit[0]),
		.wdata(hwdata),
		.wmask(mask_q),
		.power_down(ch3_power_down),
		.enable(ch3_enable),
		.reference_select(ch3_reference_select),
		.increased_drive(),
		.high_cap_load(),
		.output_code(ch3_output_code),
		.ctrl_read(ch3_ctrl_read),
		.data_read(ch3_data_read)
	);

	vdc_channel #(
		.HAS_LOAD_BITS(1)
	) u_ch4 (
		.ref_clk(ref_clk),
		.rst(rst),
		.ctrl_we(commit & ctrl_hit[1]),
		.data_we(commit & data_hit[1]),
		.wdata(hwdata),
		.wmask(mask_q),
		.power_down(ch4_power_down),
		.enable(ch4_enable),
		.reference_select(ch4_reference_select),
		.increased_drive(ch4_increased_drive),
		.high_cap_load(ch4_high_cap_load),
		.output_code(ch4_output_code),
		.ctrl_read(ch4_ctrl_read),
		.data_read(ch4_data_read)
	);

	vdc_channel #(
		.HAS_LOAD_BITS(1)
	) u_ch5 (
		.ref_clk(ref_clk),
		.rst(rst),
		.ctrl_we(commit & ctrl_hit[2]),
		.data_we(commit & data_hit[2]),
		.wdata(hwdata),
		.wmask(mask_q),
		.power_down(ch5_power_down),
		.enable(ch5_enable),
		.reference_select(ch5_reference_select),
		.increased_drive(ch5_increased_drive),
		.high_cap_load(ch5_high_cap_load),
		.output_code(ch5_output_code),
		.ctrl_read(ch5_ctrl_read),
		.data_read(ch5_data_read)
	);

	vdc_channel #(
		.HAS_LOAD_BITS(0)
	) u_ch6 (
		.ref_clk(ref_clk),
		.rst(rst),
		.ctrl_we(commit & ctrl_hit[3]),
		.data_we(commit & data_hit[3]),
		.wdata(hwdata),
		.wmask(mask_q),
		.power_down(ch6_power_down),
		.enable(ch6_enable),
		.reference_select(ch6_reference_select),
		.increased_drive(),
		.high_cap_load(),
		.output_code(ch6_output_code),
		.ctrl_read(ch6_ctrl_read),
		.data_read(ch6_data_read)
	);
endmodule // vdc_top

`default_nettype wire

// ### vdc_top_assertions.sv
/* Checker for the channel control slave.
   Assumes hready is the slave's own hreadyout and word writes only. */
`timescale 1ns/1ps
`default_nettype none
`include "vdc_regs.vh"
module vdc_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic ch3_power_down,
	input wire logic ch3_enable,
	input wire logic [11:0] ch3_output_code,
	input wire logic [1:0] ch4_reference_select,
	input wire logic ch4_increased_drive,
	input wire logic ch5_increased_drive,
	input wire logic ch5_high_cap_load,
	input wire logic ch6_enable,
	input wire logic [11:0] ch6_output_code
);
	logic wp;
	logic [31:0] aq;
	// Narrow writes are left out: lane merging is not modelled here
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp <= 1'b0;
			aq <= 32'h0;
		end else if (hready) begin
			wp <= hsel & htrans[1] & hwrite & (hsize >= 3'h2);
			aq <= haddr;
		end
	end
	// Arguments only, so every value it uses is the sampled one
	function automatic logic wl(logic p, logic r, logic [31:0] q, logic [31:0] a);
		return p && r && q == a;
	endfunction
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_rd(a);
		hsel && hready && htrans[1] && !hwrite && haddr == a;
	endsequence
	sequence s_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	a_pd_write: assert property (wl(wp, hready, aq, `VDC_CH3_CTRL_ADDR) |=>
		ch3_power_down == $past(hwdata[8]) && ch3_enable == $past(hwdata[4]))
		else $error("power-down or enable not taken from write");
	a_ref_now: assert property (wl(wp, hready, aq, `VDC_CH4_CTRL_ADDR) |=>
		ch4_reference_select == $past(hwdata[1:0])) else $error("reference select deferred");
	a_drive_load: assert property (wl(wp, hready, aq, `VDC_CH5_CTRL_ADDR) |=>
		{ch5_increased_drive, ch5_high_cap_load} == $past(hwdata[10:9]))
		else $error("drive or load bit wrong");
	a_off_clears: assert property (!ch6_enable |-> ch6_output_code == 12'h0)
		else $error("code held while disabled");
	a_code_write: assert property (ch3_enable &&
		wl(wp, hready, aq, `VDC_CH3_DATA_ADDR) |=> ch3_output_code == $past(hwdata[27:16]))
		else $error("code not written");
	a_code_hold: assert property (ch3_enable &&
		!wl(wp, hready, aq, `VDC_CH3_DATA_ADDR) && !wl(wp, hready, aq, `VDC_CH3_CTRL_ADDR)
		|=> $stable(ch3_output_code)) else $error("code moved");
	a_rsvd_ch3: assert property (s_rd(`VDC_CH3_CTRL_ADDR) |=> s_ans ##0
		hrdata[31:9] == 23'h0 && hrdata[8] == ch3_power_down) else $error("ch3 readback bad");
	a_rsvd_ch4: assert property (s_rd(`VDC_CH4_CTRL_ADDR) |=> s_ans ##0
		hrdata[31:11] == 21'h0 && hrdata[10] == ch4_increased_drive)
		else $error("ch4 readback bad");
	a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
endmodule // vdc_checker
bind vdc_top vdc_checker vdc_checker_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.ch3_power_down(ch3_power_down), .ch3_enable(ch3_enable),
	.ch3_output_code(ch3_output_code), .ch4_reference_select(ch4_reference_select),
	.ch4_increased_drive(ch4_increased_drive), .ch5_increased_drive(ch5_increased_drive),
	.ch5_high_cap_load(ch5_high_cap_load), .ch6_enable(ch6_enable),
	.ch6_output_code(ch6_output_code));
`default_nettype wire

// ### voltage_dac_channel_control_test.sv
/* Self-checking bench for the channel control slave.
   Assumes one AHB-Lite slave, so hready is hreadyout. */
`timescale 1ns/1ps
`default_nettype none
`include "vdc_regs.vh"
module voltage_dac_channel_control_test;
	logic ref_clk = 0, rst = 1, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, q, d;
	wire logic hready, hreadyout, hresp;
	wire logic [31:0] hrdata;
	wire logic pd[4], en[4], dr[4], ld[4];
	wire logic [1:0] rs[4];
	wire logic [11:0] co[4];
	int error_cnt = 0, num_checks = 0, cyc = 0, i;
	logic [15:0] ce[4];
	logic [11:0] de[4];
	assign hready = hreadyout;
	assign dr[0] = 1'b0;
	assign dr[3] = 1'b0;
	assign ld[0] = 1'b0;
	assign ld[3] = 1'b0;
	always #10 ref_clk = ~ref_clk;
	vdc_top vdc_top_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.ch3_power_down(pd[0]), .ch3_enable(en[0]), .ch3_reference_select(rs[0]),
		.ch3_output_code(co[0]), .ch4_power_down(pd[1]), .ch4_enable(en[1]),
		.ch4_reference_select(rs[1]), .ch4_increased_drive(dr[1]),
		.ch4_high_cap_load(ld[1]), .ch4_output_code(co[1]), .ch5_power_down(pd[2]),
		.ch5_enable(en[2]), .ch5_reference_select(rs[2]), .ch5_increased_drive(dr[2]),
		.ch5_high_cap_load(ld[2]), .ch5_output_code(co[2]), .ch6_power_down(pd[3]),
		.ch6_enable(en[3]), .ch6_reference_select(rs[3]), .ch6_output_code(co[3]));
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %0t seen %h want %h", $time, s, e);
		end
	endtask
	task print_verdict;
		if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Ceiling well above the under one thousand cycles the run needs
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict;
		end
	end
	task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		do @(posedge ref_clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	function logic [15:0] cmask(int c);
		return (c == 1 || c == 2) ? `VDC_CTRL_MASK_LOAD : `VDC_CTRL_MASK_BASIC;
	endfunction
	task wr(input int c, input logic dat, input logic [31:0] v);
		if (dat) begin
			xfer(1'b1, `VDC_CH3_DATA_ADDR + 4 * c, v);
			if (ce[c][4]) de[c] = v[27:16];
		end else begin
			xfer(1'b1, `VDC_CH3_CTRL_ADDR + 4 * c, v);
			ce[c] = v[15:0] & cmask(c);
			if (!v[4]) de[c] = 12'h0;
		end
	endtask
	// Outputs first, so a deferred update would show
	task look(input int c);
		@(posedge ref_clk);
		chk({5'h0, dr[c], ld[c], pd[c], 3'h0, en[c], 2'h0, rs[c]}, ce[c] & 16'h0713);
		chk(co[c], de[c]);
		xfer(1'b0, `VDC_CH3_CTRL_ADDR + 4 * c, 32'h0);
		chk(q, {16'h0, ce[c]});
		xfer(1'b0, `VDC_CH3_DATA_ADDR + 4 * c, 32'h0);
		chk(q, {4'h0, de[c], 16'h0});
	endtask
	// Reset values of all four channels
	task rst_all;
		rst <= 1'b1;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		for (i = 0; i < 4; i++) begin
			ce[i] = `VDC_CTRL_RESET;
			de[i] = 12'h0;
		end
		for (i = 0; i < 4; i++) look(i);
	endtask
	initial begin
		void'($urandom(45));
		rst_all;
		wr(0, 1'b0, 32'hffffffff);
		look(0);
		wr(1, 1'b0, 32'hffffffff);
		look(1);
		// Unmapped word just below the channel 3 control register reads zero
		xfer(1'b1, 32'h40082408, 32'hffffffff);
		xfer(1'b0, 32'h40082408, 32'h0);
		chk(q, 32'h0);
		wr(1, 1'b0, 32'h13);
		look(1);
		wr(1, 1'b0, 32'h10);
		look(1);
		// enable, load, disable clears, write lost
		wr(2, 1'b0, 32'h610);
		wr(2, 1'b1, 32'h0fff0000);
		look(2);
		wr(2, 1'b0, 32'h0);
		wr(2, 1'b1, 32'h0abc0000);
		look(2);
		repeat (80) begin
			i = $urandom % 4;
			d = $urandom;
			d[1:0] = {2{d[0]}};
			if ($urandom % 2) wr(i, 1'b1, d & 32'h0fff0000);
			else wr(i, 1'b0, d);
			look(i);
		end
		// Second reset at the end of the run
		rst_all;
		print_verdict;
	end
endmodule // voltage_dac_channel_control_test
`default_nettype wire
